// *** dfc_pkg.sv ***
package dfc_pkg;

  // ---------------------------------------------------------------
  // Widths and timing
  // ---------------------------------------------------------------
  localparam int DW       = 24;            // Result width, full scale 1.0
  localparam int W1       = 32;            // First-stage accumulators
  localparam int W2       = 76;            // Second-stage accumulators
  localparam int DEN_W    = 52;            // Divisor width
  localparam int PROD_W   = 76;            // Normaliser product width
  localparam int RECIP_SH = 32;
  localparam int S1_ORD   = 5;
  localparam int S2_ORD_MAX = 4;
  localparam int MOD_DIV  = 8;             // Modulator bit every 8 clocks
  localparam int CLK_REF_HZ = 7372800;     // Clock at which the rates are quoted

  // ---------------------------------------------------------------
  // Codes and filter constants
  // ---------------------------------------------------------------
  localparam logic [2:0]  ORD_FIR     = 3'h4;
  localparam logic [2:0]  FIR_PRE_ORD = 3'h1;
  localparam logic [12:0] FIR_PRE_B   = 13'h0018;
  localparam logic [7:0]  FIR_DEC     = 8'h1E;
  localparam logic [3:0]  RATE_BYPASS_MIN = 4'hD;
  localparam logic [63:0] ONE56    = 64'h0100000000000000;
  localparam logic [39:0] RECIP_64 = 40'h0004000000;
  localparam logic [39:0] RECIP_48 = 40'(ONE56 / 64'h000000000F300000);
  localparam logic [39:0] RECIP_24 = 40'(ONE56 / 64'h0000000000798000);

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] order;
    logic [3:0] rate;
  } dfc_cfg_t;

  typedef struct packed {
    logic          fir;
    logic [DW-1:0] data;
  } dfc_word_t;

  typedef enum logic [1:0] {DFC_IDLE, DFC_DIV, DFC_PUSH} dfc_state_t;

  typedef struct packed {
    dfc_cfg_t                     cfg;
    logic                         err;
    logic [2:0]                   phase;
    logic [6:0]                   cnt1;
    logic [S1_ORD-1:0][W1-1:0]    int1;
    logic [S1_ORD-1:0][W1-1:0]    dly1;
    logic [12:0]                  cnt2;
    logic [S2_ORD_MAX-1:0][W2-1:0] int2;
    logic [S2_ORD_MAX-1:0][W2-1:0] dly2;
    logic [7:0]                   fir_cnt;
    logic [W1-1:0]                fir_acc;
    dfc_state_t                   st;
    logic                         job_fir;
    logic [6:0]                   bitc;
    logic [W2-1:0]                num;
    logic [DEN_W-1:0]             den;
    logic [DEN_W:0]               rem;
    dfc_word_t                    out;
  } dfc_st_t;

  localparam dfc_st_t DFC_ST_RESET = '0;

  // ---------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------
  function automatic logic [6:0] ratio_a(input logic [3:0] rate);
    case (rate)
      4'hF:    return 7'h18;
      4'hE:    return 7'h30;
      default: return 7'h40;
    endcase
  endfunction

  function automatic logic [12:0] ratio_b(input logic [3:0] rate);
    case (rate)
      4'h0:    return 13'h1680;
      4'h1:    return 13'h0B40;
      4'h2:    return 13'h05A0;
      4'h3:    return 13'h0360;
      4'h4:    return 13'h02D0;
      4'h5:    return 13'h0120;
      4'h6:    return 13'h00F0;
      4'h7:    return 13'h0090;
      4'h8:    return 13'h0024;
      4'h9:    return 13'h000C;
      4'hA:    return 13'h0006;
      4'hB:    return 13'h0003;
      4'hC:    return 13'h0002;
      default: return 13'h0001;
    endcase
  endfunction

  function automatic logic fir_ok(input logic [3:0] rate);
    return (rate == 4'h0) || (rate == 4'h1) || (rate == 4'h2) || (rate == 4'h4);
  endfunction

  function automatic logic [7:0] fir_len(input logic [3:0] rate);
    case (rate)
      4'h0:    return 8'(FIR_DEC * 8'h08);
      4'h1:    return 8'(FIR_DEC * 8'h04);
      4'h2:    return 8'(FIR_DEC * 8'h02);
      default: return FIR_DEC;
    endcase
  endfunction

  function automatic logic cfg_bad(input dfc_cfg_t cfg);
    return (cfg.order > ORD_FIR) || (cfg.order == ORD_FIR && !fir_ok(cfg.rate));
  endfunction

  function automatic logic [2:0] s2_order(input dfc_cfg_t cfg);
    return (cfg.order == ORD_FIR) ? FIR_PRE_ORD : cfg.order + 3'h1;
  endfunction

  function automatic logic [12:0] s2_ratio(input dfc_cfg_t cfg);
    return (cfg.order == ORD_FIR) ? FIR_PRE_B : ratio_b(cfg.rate);
  endfunction

  function automatic logic [39:0] recip_a(input logic [6:0] a);
    case (a)
      7'h18:   return RECIP_24;
      7'h30:   return RECIP_48;
      default: return RECIP_64;
    endcase
  endfunction

  function automatic logic [DEN_W-1:0] pow_b(input logic [12:0] b, input logic [2:0] n);
    logic [DEN_W-1:0] p;
    p = DEN_W'(1);
    for (int k = 0; k < S2_ORD_MAX; k++)
    begin
      if (3'(k) < n)
      begin
        p = DEN_W'(p * DEN_W'(b));
      end
    end
    return p;
  endfunction

  function automatic logic [DW-1:0] sat(input logic [W2-1:0] x);
    return (|x[W2-1:DW]) ? {DW{1'b1}} : x[DW-1:0];
  endfunction

endpackage

// *** dfc_fifo.sv ***
`timescale 1ns/1ps
module dfc_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  // ---------------------------------------------------------------
  // Storage and pointers (DEPTH is a power of two)
  // ---------------------------------------------------------------
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } dfc_fifo_st_t;

  dfc_fifo_st_t r;
  dfc_fifo_st_t n;

  assign in_ready  = (r.wp ^ r.rp) != {1'b1, {AW{1'b0}}};
  assign out_valid = r.wp != r.rp;
  assign out_data  = r.mem[r.rp[AW-1:0]];

  always_comb
  begin
    n = r;
    if (in_valid && in_ready)
    begin
      n.mem[r.wp[AW-1:0]] = in_data;
      n.wp = r.wp + (AW+1)'(1);
    end
    if (out_valid && out_ready)
    begin
      n.rp = r.rp + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      r <= '0;
    else
      r <= n;
  end

endmodule

// *** dfc_top.sv ***
`timescale 1ns/1ps
module dfc_top
  import dfc_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic       CLK_SYS,
  input  wire logic       SYS_RST,
  input  wire logic       MOD_BIT,
  input  wire logic       MOD_VALID,
  output logic            MOD_READY,
  input  wire logic [2:0] ORDER_SELECT,
  input  wire logic [3:0] OUTPUT_RATE_SELECT,
  output dfc_word_t       OUT_WORD,
  output logic            OUT_VALID,
  input  wire logic       OUT_READY,
  output logic            CFG_ERR
);

  // ---------------------------------------------------------------
  // State and shared signals
  // ---------------------------------------------------------------
  dfc_st_t          r;
  dfc_st_t          n;
  dfc_cfg_t         cfg_in;
  logic             restart;
  logic             mod_tick;
  logic             take;
  logic             fir_mode;
  logic             bypass;
  logic             fifo_in_ready;
  logic             s1_fire;
  logic             s2_fire;
  logic [W1-1:0]    acc1;
  logic [W1-1:0]    c1;
  logic [PROD_W-1:0] prod;
  logic [DW:0]      y1;
  logic [DW-1:0]    y1_sat;
  logic [W2-1:0]    acc2;
  logic [W2-1:0]    tap2;
  logic [W2-1:0]    c2;
  logic [DEN_W:0]   rem_sh;
  logic             q_bit;
  logic [W2-1:0]    quo;
  logic [W1-1:0]    fir_sum;

  assign cfg_in   = '{order: ORDER_SELECT, rate: OUTPUT_RATE_SELECT};
  assign restart  = cfg_in != r.cfg;
  assign mod_tick = r.phase == 3'(MOD_DIV - 1);
  assign take     = mod_tick && MOD_VALID && fifo_in_ready && !r.err;
  assign fir_mode = r.cfg.order == ORD_FIR;
  assign bypass   = (r.cfg.rate >= RATE_BYPASS_MIN) && !fir_mode;
  assign y1_sat   = sat(W2'(y1));

  assign MOD_READY = fifo_in_ready;
  assign CFG_ERR   = r.err;

  // ---------------------------------------------------------------
  // Filter datapath and sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    n       = r;
    s1_fire = 1'b0;
    s2_fire = 1'b0;
    acc1    = '0;
    c1      = '0;
    prod    = '0;
    y1      = '0;
    acc2    = '0;
    tap2    = '0;
    c2      = '0;
    rem_sh  = '0;
    q_bit   = 1'b0;
    quo     = '0;
    fir_sum = '0;

    n.phase = mod_tick ? 3'h0 : r.phase + 3'h1;

    // Bit-serial restoring divider shared by both normalisations
    case (r.st)
      DFC_IDLE:
      begin
      end
      DFC_DIV:
      begin
        rem_sh = {r.rem[DEN_W-1:0], r.num[W2-1]};
        q_bit  = rem_sh >= {1'b0, r.den};
        n.rem  = q_bit ? rem_sh - {1'b0, r.den} : rem_sh;
        n.num  = {r.num[W2-2:0], q_bit};
        n.bitc = r.bitc + 7'h01;
        if (r.bitc == 7'(W2 - 1))
        begin
          quo = {r.num[W2-2:0], q_bit};
          if (fir_mode && !r.job_fir)
          begin
            // Uniform block of fir_len taps (240, 120, 60 or 30 by rate) then block average: one word per block
            fir_sum = r.fir_acc + W1'(sat(quo));
            if (r.fir_cnt == fir_len(r.cfg.rate) - 8'h01)
            begin
              n.num       = W2'(fir_sum);
              n.den       = DEN_W'(fir_len(r.cfg.rate));
              n.rem       = '0;
              n.bitc      = '0;
              n.job_fir   = 1'b1;
              n.fir_acc   = '0;
              n.fir_cnt   = '0;
            end
            else
            begin
              n.fir_acc = fir_sum;
              n.fir_cnt = r.fir_cnt + 8'h01;
              n.st      = DFC_IDLE;
            end
          end
          else
          begin
            n.out = '{fir: r.job_fir, data: sat(quo)};
            n.st  = DFC_PUSH;
          end
        end
      end
      DFC_PUSH:
      begin
        if (fifo_in_ready)
        begin
          n.st = DFC_IDLE;
        end
      end
      default:
      begin
        n.st = DFC_IDLE;
      end
    endcase

    if (take)
    begin
      // First stage: five integrators on the bit stream
      acc1 = W1'(MOD_BIT);
      for (int k = 0; k < S1_ORD; k++)
      begin
        n.int1[k] = r.int1[k] + acc1;
        acc1      = n.int1[k];
      end
      if (r.cnt1 == ratio_a(r.cfg.rate) - 7'h01)
      begin
        n.cnt1  = '0;
        s1_fire = 1'b1;
        c1      = acc1;
        for (int k = 0; k < S1_ORD; k++)
        begin
          n.dly1[k] = c1;
          c1        = c1 - r.dly1[k];
        end
        prod = PROD_W'(c1) * PROD_W'(recip_a(ratio_a(r.cfg.rate)));
        y1   = (DW+1)'(prod >> RECIP_SH);
      end
      else
      begin
        n.cnt1 = r.cnt1 + 7'h01;
      end
    end

    if (s1_fire && bypass)
    begin
      n.out = '{fir: 1'b0, data: sat(W2'(y1))};
      n.st  = DFC_PUSH;
    end
    else if (s1_fire)
    begin
      // Second stage: order N taps the integrator chain, N combs follow
      acc2 = W2'(y1);
      for (int k = 0; k < S2_ORD_MAX; k++)
      begin
        n.int2[k] = r.int2[k] + acc2;
        acc2      = n.int2[k];
        if (3'(k + 1) == s2_order(r.cfg))
        begin
          tap2 = acc2;
        end
      end
      if (r.cnt2 == s2_ratio(r.cfg) - 13'h0001)
      begin
        n.cnt2  = '0;
        s2_fire = 1'b1;
        c2      = tap2;
        for (int k = 0; k < S2_ORD_MAX; k++)
        begin
          if (3'(k) < s2_order(r.cfg))
          begin
            n.dly2[k] = c2;
            c2        = c2 - r.dly2[k];
          end
        end
        n.num     = c2;
        n.den     = pow_b(s2_ratio(r.cfg), s2_order(r.cfg));
        n.rem     = '0;
        n.bitc    = '0;
        n.job_fir = 1'b0;
        n.st      = DFC_DIV;
      end
      else
      begin
        n.cnt2 = r.cnt2 + 13'h0001;
      end
    end

    // Any change of selection restarts the filters from a clean state
    if (restart)
    begin
      n       = DFC_ST_RESET;
      n.cfg   = cfg_in;
      n.err   = cfg_bad(cfg_in);
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      r <= DFC_ST_RESET;
    else
      r <= n;
  end

  // ---------------------------------------------------------------
  // Output buffer
  // ---------------------------------------------------------------
  dfc_fifo #(
    .WIDTH ($bits(dfc_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK_SYS),
    .rst       (SYS_RST),
    .in_valid  (r.st == DFC_PUSH),
    .in_ready  (fifo_in_ready),
    .in_data   (r.out),
    .out_valid (OUT_VALID),
    .out_ready (OUT_READY),
    .out_data  (OUT_WORD)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [19:0] take_cnt;
  logic        primed;
  logic        conv_fire;

  assign conv_fire = (s1_fire && bypass) || s2_fire;

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST || restart)
    begin
      take_cnt <= '0;
      primed   <= 1'b0;
    end
    else if (conv_fire)
    begin
      take_cnt <= '0;
      primed   <= 1'b1;
    end
    else if (take)
    begin
      take_cnt <= take_cnt + 20'h00001;
    end
  end

  sequence tick_gap;
    !mod_tick [*7] ##1 mod_tick;
  endsequence

  sequence div_run;
    (r.st == DFC_DIV) [*8];
  endsequence

  mod_rate_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST || restart)
    mod_tick |=> tick_gap)
    else $error("modulator sample strobe not every eighth clock");

  conv_rate_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST || restart)
    conv_fire && primed |-> take_cnt + 20'h00001 ==
      20'(ratio_a(r.cfg.rate)) * 20'(bypass ? 13'h0001 : s2_ratio(r.cfg)))
    else $error("conversion not after A times B modulator samples");

  bypass_out_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST || restart)
    s1_fire && bypass |=> r.st == DFC_PUSH && r.out.data == $past(y1_sat) && !r.out.fir)
    else $error("bypass rate did not deliver first-stage word");

  s2_source_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST || restart)
    s2_fire |-> ratio_a(r.cfg.rate) == 7'h40 && !bypass && s1_fire)
    else $error("second stage fired without 14400-rate input");

  order_den_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST || restart)
    s2_fire && !fir_mode |=> r.den == pow_b(ratio_b(r.cfg.rate), r.cfg.order + 3'h1) && r.cfg.order < ORD_FIR)
    else $error("second-stage gain does not match selected order");

  div_len_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST || restart)
    s2_fire && !fir_mode |=> div_run ##68 (r.st == DFC_DIV) ##1 (r.st == DFC_PUSH))
    else $error("normalisation divide not 76 cycles");

  fir_gate_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST || restart)
    r.st == DFC_PUSH && r.out.fir |-> fir_ok(r.cfg.rate) && fir_mode && !CFG_ERR)
    else $error("FIR word produced with illegal rate code");

  err_block_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    CFG_ERR |-> !take && r.st == DFC_IDLE)
    else $error("filter ran under a bad selection");

  fir_block_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST || restart)
    $rose(r.job_fir) |-> r.den == DEN_W'(fir_len(r.cfg.rate)) && r.fir_cnt == 8'h00)
    else $error("FIR block length wrong for rate");

  push_hold_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST || restart)
    r.st == DFC_PUSH && !fifo_in_ready |=> r.st == DFC_PUSH && $stable(r.out))
    else $error("result lost while buffer full");

endmodule

// *** dfc_mod_src.sv ***
`timescale 1ns/1ps
module dfc_mod_src (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] mask,
  input  wire logic       stall,
  input  wire logic       mod_ready,
  output logic            mod_bit,
  output logic            mod_valid
);
  logic [2:0] slot_reg;
  logic [2:0] idx_reg;
  logic [2:0] idx_next;

  assign idx_next = idx_reg + {2'h0, mod_valid & mod_ready};

  // ---------------------------------------------------------------
  // Bit source, one bit per slot of 8 clocks
  // ---------------------------------------------------------------
  // A skipped slot shows the inverted bit so a wrongly taken bit shows up
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      slot_reg  <= 3'h0;
      idx_reg   <= 3'h0;
      mod_valid <= 1'b0;
      mod_bit   <= 1'b0;
    end
    else
    begin
      slot_reg <= slot_reg + 3'h1;
      if (slot_reg == 3'h7)
      begin
        idx_reg   <= idx_next;
        mod_valid <= !stall;
        mod_bit   <= stall ? !mod_bit : mask[idx_next];
      end
    end
  end
endmodule

// *** decimation_filter_chain_test.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("Error %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end
module decimation_filter_chain_test;
  import dfc_pkg::*;

  logic        CLK_SYS;
  logic        SYS_RST;
  logic        MOD_BIT;
  logic        MOD_VALID;
  logic        MOD_READY;
  logic [2:0]  ORDER_SELECT;
  logic [3:0]  OUTPUT_RATE_SELECT;
  dfc_word_t   OUT_WORD;
  logic        OUT_VALID;
  logic        OUT_READY;
  logic        CFG_ERR;
  logic [7:0]  mask;
  logic        stall;
  logic        slow;
  logic [31:0] seed;
  int          num_errors;
  int          checks;
  int          cycles;
  dfc_word_t   got_q[$];
  int          stamp_q[$];

  dfc_top #(.FIFO_DEPTH(4)) dut (
    .CLK_SYS            (CLK_SYS),
    .SYS_RST            (SYS_RST),
    .MOD_BIT            (MOD_BIT),
    .MOD_VALID          (MOD_VALID),
    .MOD_READY          (MOD_READY),
    .ORDER_SELECT       (ORDER_SELECT),
    .OUTPUT_RATE_SELECT (OUTPUT_RATE_SELECT),
    .OUT_WORD           (OUT_WORD),
    .OUT_VALID          (OUT_VALID),
    .OUT_READY          (OUT_READY),
    .CFG_ERR            (CFG_ERR)
  );

  dfc_mod_src src (
    .clk       (CLK_SYS),
    .rst       (SYS_RST),
    .mask      (mask),
    .stall     (stall),
    .mod_ready (MOD_READY),
    .mod_bit   (MOD_BIT),
    .mod_valid (MOD_VALID)
  );

  initial CLK_SYS = 1'b0;
  always #50 CLK_SYS = ~CLK_SYS;

  // ---------------------------------------------------------------
  // Model and helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Settled result of a periodic stream is its ones density
  function automatic logic [23:0] expect_data(input logic [7:0] m);
    int k;
    k = $countones(m);
    return (k == 8) ? 24'hFFFFFF : 24'(k << 21);
  endfunction

  task automatic summarize();
    if (num_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wait_words(input int n, input int lim);
    int c;
    c = 0;
    while (got_q.size() < n && c < lim)
    begin
      @(negedge CLK_SYS);
      c++;
    end
    `CHK(got_q.size() >= n, 1'b1)
  endtask

  // Truncated reciprocal of ratios 24 and 48 may read one step low
  task automatic check_word(input int i, input logic [7:0] m, input int a, input int period);
    dfc_word_t w;
    logic [23:0] e;
    w = got_q[i];
    e = expect_data(m);
    if (a != 64 && e != 24'h0 && w.data === e - 24'h1)
      w.data = e;
    `CHK(w.data, e)
    `CHK(w.fir, 1'b0)
    if (period > 0)
      `CHK(stamp_q[i] - stamp_q[i - 1], period)
  endtask

  task automatic run_rate(input logic [2:0] ord, input logic [3:0] rate, input int a, input int b);
    @(negedge CLK_SYS);
    ORDER_SELECT = ord;
    OUTPUT_RATE_SELECT = rate;
    mask = 8'(rnd());
    repeat (2) @(negedge CLK_SYS);
    got_q.delete();
    stamp_q.delete();
    wait_words(10, a * b * 8 * 14);
    for (int i = 5; i < 10; i++)
      check_word(i, mask, a, a * b * 8);
  endtask

  // ---------------------------------------------------------------
  // Monitor and time limit
  // ---------------------------------------------------------------
  always @(posedge CLK_SYS)
  begin
    cycles++;
    if (OUT_VALID === 1'b1 && OUT_READY === 1'b1 && SYS_RST === 1'b0)
    begin
      got_q.push_back(OUT_WORD);
      stamp_q.push_back(cycles);
    end
    if (cycles == 90000)
    begin
      num_errors++;
      $display("Error %0t: time limit reached", $time);
      summarize();
    end
  end

  always @(negedge CLK_SYS)
    stall <= slow & 1'(rnd());

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial
  begin
    seed = 32'h02F26B92;
    num_errors = 0;
    checks = 0;
    SYS_RST = 1'b1;
    ORDER_SELECT = 3'h0;
    OUTPUT_RATE_SELECT = 4'hF;
    OUT_READY = 1'b1;
    mask = 8'hFF;
    slow = 1'b0;
    repeat (6) @(negedge CLK_SYS);
    `CHK(OUT_VALID, 1'b0)
    `CHK(MOD_READY, 1'b1)
    `CHK(CFG_ERR, 1'b0)
    SYS_RST = 1'b0;
    run_rate(3'h0, 4'hD, 64, 1);
    run_rate(3'h1, 4'hE, 48, 1);
    run_rate(3'h3, 4'hF, 24, 1);
    for (int n = 0; n < 4; n++)
      run_rate(3'(n), (n < 2) ? 4'hC : 4'hB, 64, (n < 2) ? 2 : 3);
    for (int n = 0; n < 64; n++)
    begin
      @(negedge CLK_SYS);
      ORDER_SELECT = 3'(4 + n / 16);
      OUTPUT_RATE_SELECT = 4'(n);
      repeat (4) @(negedge CLK_SYS);
      `CHK(CFG_ERR, 1'(n >= 16 || !(n == 0 || n == 1 || n == 2 || n == 4)))
    end
    repeat (200) @(negedge CLK_SYS);
    got_q.delete();
    repeat (1000) @(negedge CLK_SYS);
    `CHK(got_q.size(), 0)
    ORDER_SELECT = 3'h0;
    OUTPUT_RATE_SELECT = 4'hF;
    mask = 8'hFF;
    got_q.delete();
    wait_words(8, 4000);
    OUT_READY = 1'b0;
    slow = 1'b1;
    for (int c = 0; c < 6000 && MOD_READY !== 1'b0; c++)
      @(negedge CLK_SYS);
    `CHK(MOD_READY, 1'b0)
    `CHK(OUT_VALID, 1'b1)
    repeat (400) @(negedge CLK_SYS);
    `CHK(MOD_READY, 1'b0)
    got_q.delete();
    stamp_q.delete();
    for (int c = 0; c < 6000 && got_q.size() < 6; c++)
    begin
      @(negedge CLK_SYS);
      OUT_READY = 1'(rnd());
    end
    for (int i = 0; i < 6; i++)
      check_word(i, 8'hFF, 24, 0);
    OUT_READY = 1'b0;
    for (int c = 0; c < 6000 && MOD_READY !== 1'b0; c++)
      @(negedge CLK_SYS);
    SYS_RST = 1'b1;
    repeat (2) @(negedge CLK_SYS);
    `CHK(OUT_VALID, 1'b0)
    `CHK(MOD_READY, 1'b1)
    SYS_RST = 1'b0;
    summarize();
  end
endmodule
